// ===== src/odf_pkg.sv
// Constants, field layout and carrier types for the output data formatter
package odf_pkg;

	// Sample word geometry
	localparam int SAMPLE_W = 12;
	localparam int SAMPLE_MSB = 11;

	// Serial configuration word geometry
	localparam int SPI_WORD_W = 16;
	localparam int SPI_CNT_W = 5;
	localparam logic [4:0] SPI_BITS_ALL = 5'h10;
	localparam logic [4:0] SPI_BIT_LAST = 5'h0f;
	localparam logic [4:0] SPI_HDR_LAST = 5'h07;
	localparam logic [4:0] SPI_DATA_FIRST = 5'h09;
	localparam int SPI_RW_POS = 15;
	localparam int SPI_ADDR_HI = 14;
	localparam int SPI_ADDR_LO = 8;
	localparam int SPI_DATA_HI = 7;
	localparam int SPI_DATA_LO = 0;

	// Register addresses
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic [6:0] ADDR_FORMAT = 7'h04;
	localparam int RESET_BIT = 7;

	// Format register field positions
	localparam int CTRL_USED_W = 6;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [1:0] CTRL_UNUSED_READ = 2'h0;
	localparam logic [7:0] READ_NONE = 8'h00;

	// Test pattern codes
	localparam logic [2:0] TP_OFF = 3'h0;
	localparam logic [2:0] TP_ZERO = 3'h1;
	localparam logic [2:0] TP_ONE = 3'h3;
	localparam logic [2:0] TP_CHECK = 3'h5;
	localparam logic [2:0] TP_ALT = 3'h7;

	// Pattern values, overrange flag in the top bit
	localparam logic [12:0] PAT_ZERO = 13'h0000;
	localparam logic [12:0] PAT_ONES = 13'h1fff;
	localparam logic [12:0] PAT_CHECK_A = 13'h1555;
	localparam logic [12:0] PAT_CHECK_B = 13'h0aaa;

	// Sample bits inverted in alternate polarity mode
	localparam logic [11:0] ABP_MASK = 12'haaa;

	// Default buffer depth
	localparam int FIFO_DEPTH = 8;

	typedef struct packed {
		logic overrange_flag;
		logic [11:0] sample_bits;
	} odf_word_t;

	typedef struct packed {
		logic [2:0] test_pattern_select;
		logic alternate_polarity_enable;
		logic output_scramble_enable;
		logic signed_format_select;
	} odf_ctrl_t;

	typedef enum logic [1:0] {
		ODF_IDLE = 2'b00,
		ODF_SHIFT = 2'b01,
		ODF_DONE = 2'b10
	} odf_spi_state_t;

endpackage

// ===== src/odf_fifo.sv
// Word buffer between the formatter and the capture logic
`timescale 1ns/1ps
module odf_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

	// Pointer wrap relies on a power of two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("odf_fifo: DEPTH must be a power of two, at least 2");
	end
	if (WIDTH < 1)
	begin : g_bad_width
		$error("odf_fifo: WIDTH must be positive");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0] count;
	logic push;
	logic pop;

	// Honest flags from the occupancy count
	assign in_ready = (count != FULL_CNT);
	assign out_valid = (count != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	// Storage, no reset needed on data
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers and count
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

endmodule

// ===== src/odf_formatter.sv
// Output data formatter: serial control register, pattern and coding logic, output buffer
`timescale 1ns/1ps
// Notes on behaviour
// - The format controls live in an 8-bit register at address 04h whose bits 7 and 6 are ignored on write.
// - Test pattern field 000 passes the normal conversion results through.
// - Field 001 drives every output to 0 and field 011 drives every output to 1.
// - Field 101 alternates word by word between 1 0101 0101 0101 and 0 1010 1010 1010.
// - Field 111 alternates word by word between all zeros and all ones.
// - Bit 2 turns alternate bit polarity off at 0 and on at 1.
// - Bit 1 turns the output randomizer off at 0 and on at 1.
// - Bit 0 selects offset binary at 0 and two's complement at 1.
// - Alternate bit polarity on forces offset binary whatever bit 0 holds.
// - A software reset write clears the format register to zero.
module odf_formatter
	import odf_pkg::*;
#(
	parameter int BUF_DEPTH = odf_pkg::FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_sdi,
	output logic spi_sdo_o,
	output logic spi_sdo_oe_n,
	input wire logic adc_valid,
	output logic adc_ready,
	input wire odf_pkg::odf_word_t adc_word,
	output logic out_valid,
	input wire logic out_ready,
	output odf_pkg::odf_word_t out_word
);
	import odf_pkg::*;

	localparam int WORD_W = $bits(odf_word_t);

	if (BUF_DEPTH < 2)
	begin : g_bad_buf
		$error("odf_formatter: BUF_DEPTH must be at least 2");
	end

	// Applies coding, randomizer and polarity to a live sample
	function automatic odf_word_t encode_sample(input odf_word_t in, input odf_ctrl_t c);
		odf_word_t w;
		w = in;
		// Polarity mode overrides the signed select
		if (c.signed_format_select && !c.alternate_polarity_enable)
			w.sample_bits[SAMPLE_MSB] = ~w.sample_bits[SAMPLE_MSB];
		// Scramble before polarity so the receiver undoes polarity first
		if (c.output_scramble_enable)
			w.sample_bits[SAMPLE_MSB:1] = w.sample_bits[SAMPLE_MSB:1] ^ {(SAMPLE_W-1){w.sample_bits[0]}};
		if (c.alternate_polarity_enable)
			w.sample_bits = w.sample_bits ^ ABP_MASK;
		return w;
	endfunction

	// Chooses a test pattern or the encoded sample
	function automatic odf_word_t format_word(input odf_word_t in, input odf_ctrl_t c, input logic phase);
		odf_word_t w;
		w = encode_sample(in, c);
		case (c.test_pattern_select)
			TP_OFF: w = encode_sample(in, c);
			TP_ZERO: w = PAT_ZERO;
			TP_ONE: w = PAT_ONES;
			TP_CHECK: w = phase ? PAT_CHECK_B : PAT_CHECK_A;
			TP_ALT: w = phase ? PAT_ONES : PAT_ZERO;
			// Unused codes fall back to live data
			default: w = encode_sample(in, c);
		endcase
		return w;
	endfunction

	// Read data for a register address
	function automatic logic [7:0] read_value(input logic [6:0] addr, input odf_ctrl_t c);
		logic [7:0] v;
		v = READ_NONE;
		if (addr == ADDR_FORMAT)
			v = {CTRL_UNUSED_READ, c};
		return v;
	endfunction

	// Serial pins come from another domain
	logic cs_s1;
	logic cs_s2;
	logic sck_s1;
	logic sck_s2;
	logic sck_s3;
	logic sdi_s1;
	logic sdi_s2;
	logic sck_rise;
	logic sck_fall;

	odf_spi_state_t state;
	logic [SPI_CNT_W-1:0] bit_cnt;
	logic [SPI_WORD_W-1:0] shreg;
	logic [7:0] rd_shift;
	logic rd_en;
	logic commit;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_data;

	odf_ctrl_t ctrl;
	logic phase;
	logic push;
	odf_word_t fmt_word;
	logic [WORD_W-1:0] buf_out;

	// Two-stage synchronisers plus an edge stage
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
		end
		else
		begin
			cs_s1 <= spi_cs_n;
			cs_s2 <= cs_s1;
			sck_s1 <= spi_sck;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			sdi_s1 <= spi_sdi;
			sdi_s2 <= sdi_s1;
		end
	end

	// Edges seen on synchronised levels only
	assign sck_rise = sck_s2 & ~sck_s3;
	assign sck_fall = ~sck_s2 & sck_s3;

	// Frame sequencer; clocks past the sixteenth are ignored
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ODF_IDLE;
			bit_cnt <= '0;
			shreg <= '0;
		end
		else
		begin
			case (state)
				ODF_IDLE:
				begin
					bit_cnt <= '0;
					if (!cs_s2)
						state <= ODF_SHIFT;
				end
				ODF_SHIFT:
				begin
					// Short frame is dropped without effect
					if (cs_s2)
						state <= ODF_IDLE;
					else if (sck_rise)
					begin
						shreg <= {shreg[SPI_WORD_W-2:0], sdi_s2};
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == SPI_BIT_LAST)
							state <= ODF_DONE;
					end
				end
				ODF_DONE:
				begin
					if (cs_s2)
						state <= ODF_IDLE;
				end
				default: state <= ODF_IDLE;
			endcase
		end
	end

	// Command fields of a complete word
	assign cmd_addr = shreg[SPI_ADDR_HI:SPI_ADDR_LO];
	assign cmd_data = shreg[SPI_DATA_HI:SPI_DATA_LO];
	// Write takes effect when the frame closes
	assign commit = (state == ODF_DONE) && cs_s2 && (bit_cnt == SPI_BITS_ALL) && !shreg[SPI_RW_POS];

	// Format control register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ctrl <= CTRL_RESET;
		else if (commit)
		begin
			if (cmd_addr == ADDR_RESET && cmd_data[RESET_BIT])
				ctrl <= CTRL_RESET;
			else if (cmd_addr == ADDR_FORMAT)
				ctrl <= cmd_data[CTRL_USED_W-1:0];
		end
	end

	// Readback shifter; data moves on falling clock
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rd_en <= 1'b0;
			rd_shift <= READ_NONE;
		end
		else if (state != ODF_SHIFT)
		begin
			rd_en <= 1'b0;
			rd_shift <= READ_NONE;
		end
		else if (sck_rise && bit_cnt == SPI_HDR_LAST)
		begin
			// Header complete: bit 6 of shreg is the read flag
			rd_en <= shreg[6];
			rd_shift <= read_value({shreg[5:0], sdi_s2}, ctrl);
		end
		else if (sck_fall && rd_en && bit_cnt >= SPI_DATA_FIRST)
			rd_shift <= {rd_shift[6:0], 1'b0};
	end

	// Open drain: only ever pulls low
	assign spi_sdo_o = 1'b0;
	assign spi_sdo_oe_n = ~(rd_en & ~rd_shift[7]);

	// Pattern phase steps once per accepted word in modes 101 and 111, held at 0 otherwise
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			phase <= 1'b0;
		else if (ctrl.test_pattern_select != TP_CHECK && ctrl.test_pattern_select != TP_ALT)
			phase <= 1'b0;
		else if (push)
			phase <= ~phase;
	end

	// Converter cannot be held, so a full buffer shows on adc_ready
	assign push = adc_valid & adc_ready;
	assign fmt_word = format_word(adc_word, ctrl, phase);

	odf_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(adc_valid),
		.in_ready(adc_ready),
		.in_data(fmt_word),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(buf_out)
	);

	assign out_word = buf_out;

endmodule

// ===== verif/odf_formatter_props.sv
// Port checker for the output data formatter
`timescale 1ns/1ps
module odf_formatter_props
	import odf_pkg::*;
#(
	parameter int BUF_DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_sdi,
	input wire logic spi_sdo_o,
	input wire logic spi_sdo_oe_n,
	input wire logic adc_valid,
	input wire logic adc_ready,
	input wire odf_pkg::odf_word_t adc_word,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire odf_pkg::odf_word_t out_word
);
	int cnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Own fill count, so a wrong count in the buffer shows up
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			cnt <= 0;
		else
			cnt <= cnt + int'(adc_valid && adc_ready) - int'(out_valid && out_ready);
	end
	property p_ready;
		adc_ready == (cnt != BUF_DEPTH);
	endproperty
	a_ready: assert property (p_ready) else $error("ready wrong for fill");
	property p_valid;
		out_valid == (cnt != 0);
	endproperty
	a_valid: assert property (p_valid) else $error("valid wrong for fill");
	property p_stand;
		out_valid && !out_ready |=> out_valid && $stable(out_word);
	endproperty
	a_stand: assert property (p_stand) else $error("word moved while stalled");
	property p_push_empty;
		!out_valid && adc_valid |=> out_valid;
	endproperty
	a_push_empty: assert property (p_push_empty) else $error("push not seen");
	property p_full_stall;
		!adc_ready && !out_ready |=> !adc_ready;
	endproperty
	a_full_stall: assert property (p_full_stall) else $error("full buffer freed");
	property p_pop_full;
		!adc_ready && out_ready |=> adc_ready;
	endproperty
	a_pop_full: assert property (p_pop_full) else $error("pop left buffer full");
	// Pulling low only inside a frame; select seen through a four cycle lag
	property p_sdo_low;
		!spi_sdo_oe_n |-> spi_sdo_o == 1'b0 && !$past(spi_cs_n, 4);
	endproperty
	a_sdo_low: assert property (p_sdo_low) else $error("drain active outside frame");
	property p_idle;
		spi_cs_n [*6] |-> spi_sdo_oe_n;
	endproperty
	a_idle: assert property (p_idle) else $error("data line held outside frame");
endmodule

// ===== verif/odf_capture.sv
// Downstream capture model that can stall
`timescale 1ns/1ps
module odf_capture
	import odf_pkg::*;
(
	input wire logic core_clk,
	input wire logic stall,
	input wire logic out_valid,
	output logic out_ready,
	input wire odf_pkg::odf_word_t out_word
);
	odf_word_t got[$];
	// Ready only when not stalled; words kept in arrival order
	assign out_ready = !stall;
	always @(posedge core_clk)
	begin
		if (out_valid && out_ready)
			got.push_back(out_word);
	end
endmodule

// ===== verif/tb_odf_formatter.sv
// Self-checking bench for the output data formatter
`timescale 1ns/1ps
module tb_odf_formatter;
	import odf_pkg::*;
	typedef struct { logic [7:0] c; odf_word_t i; odf_word_t e; } odf_row_t;
	logic core_clk, rst, spi_cs_n, spi_sck, spi_sdi, spi_sdo_o, spi_sdo_oe_n;
	logic adc_valid, adc_ready, out_valid, out_ready, stall;
	odf_word_t adc_word, out_word;
	int errors, checked;
	logic [7:0] rd;
	wire sdo = spi_sdo_oe_n ? 1'b1 : spi_sdo_o;
	// Control byte, input word, formatted word
	odf_row_t rows [10] = '{'{8'h00, 13'h0123, 13'h0123}, '{8'h01, 13'h0123, 13'h0923},
		'{8'h04, 13'h0123, 13'h0b89}, '{8'h05, 13'h0123, 13'h0b89}, '{8'h02, 13'h0123, 13'h0edd},
		'{8'hc0, 13'h1123, 13'h1123}, '{8'h08, 13'h1123, 13'h0000}, '{8'h18, 13'h0123, 13'h1fff},
		'{8'h03, 13'h0123, 13'h06dd}, '{8'h06, 13'h1123, 13'h1477}};
	odf_formatter #(.BUF_DEPTH(8)) odf_formatter_inst (.core_clk(core_clk), .rst(rst), .spi_cs_n(spi_cs_n),
		.spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_n(spi_sdo_oe_n),
		.adc_valid(adc_valid), .adc_ready(adc_ready), .adc_word(adc_word), .out_valid(out_valid),
		.out_ready(out_ready), .out_word(out_word));
	odf_capture odf_capture_inst (.core_clk(core_clk), .stall(stall), .out_valid(out_valid),
		.out_ready(out_ready), .out_word(out_word));
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Phases of five cycles so the synchroniser sees every edge
	task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] d);
		logic [15:0] w;
		w = {rw, a, d};
		spi_cs_n <= 0;
		tick(5);
		for (int k = 15; k >= 0; k--)
		begin
			spi_sdi <= w[k];
			tick(4);
			@(negedge core_clk);
			rd[k[2:0]] = sdo;
			@(posedge core_clk);
			spi_sck <= 1;
			tick(5);
			spi_sck <= 0;
		end
		tick(5);
		spi_cs_n <= 1;
		spi_sdi <= ~spi_sdi;
		tick(8);
	endtask
	// Extra edge after each word keeps valid from being driven twice at once
	task automatic push(input odf_word_t w);
		adc_valid <= 1;
		adc_word <= w;
		for (int k = 0; k < 100; k++)
		begin
			@(negedge core_clk);
			if (adc_ready === 1'b1)
			begin
				@(posedge core_clk);
				adc_valid <= 0;
				adc_word <= ~w;
				tick(1);
				return;
			end
		end
		errors++;
		end_sim;
	endtask
	task automatic pull(input odf_word_t e, input string nm);
		for (int k = 0; k < 100 && odf_capture_inst.got.size() == 0; k++)
			tick(1);
		if (odf_capture_inst.got.size() == 0)
		begin
			errors++;
			end_sim;
		end
		check(nm, odf_capture_inst.got.pop_front(), e);
	endtask
	initial
	begin
		core_clk = 0;
		forever #4 core_clk = ~core_clk;
	end
	initial
	begin
		rst = 1;
		spi_cs_n = 1;
		spi_sck = 0;
		spi_sdi = 0;
		adc_valid = 0;
		adc_word = '0;
		stall = 0;
		errors = 0;
		checked = 0;
		tick(20);
		rst <= 0;
		tick(4);
		spi(1, 7'h04, 8'h00);
		check("reg_rst", {5'h0, rd}, 13'h0000);
		foreach (rows[r])
		begin
			spi(0, 7'h04, rows[r].c);
			spi(1, 7'h04, 8'h00);
			check("reg", {5'h0, rows[r].c & 8'h3f}, {5'h0, rd});
			push(rows[r].i);
			pull(rows[r].e, "row");
		end
		// Only defined pattern codes are written
		spi(0, 7'h04, 8'h28);
		for (int k = 0; k < 3; k++)
			push(13'h0456);
		for (int k = 0; k < 3; k++)
			pull(k[0] ? 13'h0aaa : 13'h1555, "checker");
		spi(0, 7'h04, 8'h00);
		spi(0, 7'h04, 8'h38);
		for (int k = 0; k < 3; k++)
			push(13'h0456);
		for (int k = 0; k < 3; k++)
			pull(k[0] ? 13'h1fff : 13'h0000, "alternate");
		// Write elsewhere and a read leave the register alone
		spi(0, 7'h05, 8'h3f);
		spi(1, 7'h04, 8'h00);
		check("other_addr", {5'h0, rd}, 13'h0038);
		spi(0, 7'h00, 8'h80);
		spi(1, 7'h04, 8'h00);
		check("soft_rst", {5'h0, rd}, 13'h0000);
		// Fill while the far side stalls, then drain in order
		stall <= 1;
		for (int k = 0; k < 8; k++)
			push({1'b0, 12'(k * 3)});
		@(negedge core_clk);
		check("full", {12'h0, adc_ready}, 13'h0000);
		@(posedge core_clk);
		stall <= 0;
		for (int k = 0; k < 8; k++)
			pull({1'b0, 12'(k * 3)}, "drain");
		// Reset in mid-run drops buffered words and clears the register
		stall <= 1;
		spi(0, 7'h04, 8'h06);
		push(13'h0123);
		check("pre_rst", {12'h0, out_valid}, 13'h0001);
		rst <= 1;
		tick(2);
		check("rst_valid", {12'h0, out_valid}, 13'h0000);
		check("rst_ready", {12'h0, adc_ready}, 13'h0001);
		rst <= 0;
		stall <= 0;
		tick(4);
		spi(1, 7'h04, 8'h00);
		check("rst_reg", {5'h0, rd}, 13'h0000);
		push(13'h0123);
		pull(13'h0123, "rst_data");
		end_sim;
	end
endmodule
bind odf_formatter odf_formatter_props #(.BUF_DEPTH(BUF_DEPTH)) odf_formatter_props_inst (.core_clk(core_clk),
	.rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o),
	.spi_sdo_oe_n(spi_sdo_oe_n), .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_word(adc_word),
	.out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
